// >>> common/power_manager_pkg.sv
package power_manager_pkg;

  // ************************************************************
  // Register map (APB byte addresses)
  // ************************************************************
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] timer_offset = 8'h04;
  localparam logic [7:0] status_offset = 8'h08;
  localparam logic [7:0] detect_offset = 8'h0C;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int apd_enable_bit = 0;
  localparam int autoneg_enable_bit = 1;
  localparam int detect_enable_bit = 2;
  localparam int forced_speed_bit = 3;
  localparam int interrupt_enable_bit = 4;
  localparam int sleep_field_lsb = 0;
  localparam int wake_field_lsb = 2;
  localparam int link_timeout_lo_bit = 4;
  localparam int link_timeout_hi_bit = 5;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [4:0] ctrl_reset = 5'h02;
  localparam logic [5:0] timer_reset = 6'h01;

  // ************************************************************
  // Detection status codes
  // ************************************************************
  localparam logic [1:0] detect_searching = 2'h0;
  localparam logic [1:0] detect_found = 2'h1;
  localparam logic [1:0] detect_none = 2'h2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int clock_hz = 10_000_000;
  localparam int sleep_base_ms = 1000;
  localparam int wake_base_ms = 250;
  localparam int link_timeout_base_ms = 500;
  localparam int detect_timeout_ms = 100;
  localparam int random_span_ms = 140;
  localparam int cycles_per_ms = clock_hz / 1000;
  localparam int sleep_base_cycles = sleep_base_ms * cycles_per_ms;
  localparam int wake_base_cycles = wake_base_ms * cycles_per_ms;
  localparam int link_timeout_base_cycles = link_timeout_base_ms * cycles_per_ms;
  localparam int detect_timeout_cycles = detect_timeout_ms * cycles_per_ms;
  localparam int random_span_cycles = random_span_ms * cycles_per_ms;
  localparam int burst_count = 3;

  typedef enum logic [1:0] {
    low_power = 2'b00,
    partner_wake = 2'b01,
    normal_op = 2'b11
  } apd_state_type;

endpackage : power_manager_pkg

// >>> verilog/energy_sync.sv
`timescale 1ns/1ns
module energy_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Asynchronous level in, clean level out
  input wire logic async_in,
  output logic sync_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Change counts only once stage2 and stage3 agree
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        sync_out <= stage3;
      end
    end
  end

endmodule : energy_sync

// >>> verilog/phy_link_power_manager.sv
`timescale 1ns/1ns
// Overview of operation
// RULE1: Software enable bit switches power-down machine anytime
// RULE2: Three states: low power, wake, normal
// RULE3: No energy: alternate sleep and wake periodically
// RULE4: Energy detected moves machine to normal
// RULE5: Link fail with autoneg: timeout, then low power
// RULE6: Reset always starts in low power
// RULE7: Forced speed: cycle, then stay normal
// RULE8: Autoneg off in normal: stay on drop
// RULE9: Low power gates digital blocks, management alive
// RULE10: Low power watches energy, leaves straight to normal
// RULE11: Wake state transmits fast link pulse bursts
// RULE12: Detection enable plus autoneg starts search
// RULE13: Search sends special pulses, status reads 00
// RULE14: Looped-back pulses set status 01
// RULE15: Detection sets interrupt bit, read clears it
// RULE16: No loop-back within timeout sets status 10
// RULE17: Status 10 starts autoneg, link sets status
// RULE18: Link failure resumes powered-device detection
// RULE19: Switch applies and removes inline power itself
// RULE20: Two-bit sleep field, randomized dwell
// RULE21: Up to three bursts alternating pairs A, B
// RULE22: Link timeout set by two config bits
// RULE23: Energy input synchronized before use
// RULE24: Timeouts are parameters meeting two-second default
module phy_link_power_manager
  import power_manager_pkg::*;
#(
  parameter int sleep_cycles = sleep_base_cycles,
  parameter int wake_cycles = wake_base_cycles,
  parameter int link_cycles = link_timeout_base_cycles,
  parameter int detect_cycles = detect_timeout_cycles,
  parameter int jitter_cycles = random_span_cycles
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Media side
  input wire logic energy_detect,
  input wire logic link_up,
  input wire logic pulse_loopback,
  output logic pulse_tx,
  output logic pulse_pair_b,
  output logic detect_pulse_tx,
  output logic autoneg_run,
  output logic digital_power_en,
  // Management interrupt, open drain
  output logic management_interrupt_n_o,
  output logic management_interrupt_n_oe
);

  // ************************************************************
  // Registers and wires
  // ************************************************************
  logic [4:0] ctrl;
  logic [5:0] timer_cfg;
  logic [31:0] count;
  logic [15:0] lfsr;
  logic [1:0] burst_idx;
  logic [1:0] detect_status;
  logic detect_active;
  logic [31:0] detect_count;
  logic detect_irq;
  logic link_seen;
  logic energy;
  logic sticky_normal;
  apd_state_type state;
  apd_state_type next_state;

  wire apd_en = ctrl[apd_enable_bit];
  wire an_en = ctrl[autoneg_enable_bit];
  wire det_en = ctrl[detect_enable_bit];
  wire forced = ctrl[forced_speed_bit];
  wire irq_en = ctrl[interrupt_enable_bit];
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_ctrl = paddr == ctrl_offset;
  wire hit_timer = paddr == timer_offset;
  wire hit_status = paddr == status_offset;
  wire hit_detect = paddr == detect_offset;
  wire mapped = hit_ctrl || hit_timer || hit_status || hit_detect;
  wire [1:0] sleep_sel = timer_cfg[sleep_field_lsb +: 2];
  wire [1:0] wake_sel = timer_cfg[wake_field_lsb +: 2];
  wire [1:0] link_sel = {timer_cfg[link_timeout_hi_bit], timer_cfg[link_timeout_lo_bit]};

  // Scale a base period by a two-bit field: 1x, 2x, 3x, 4x
  function automatic logic [31:0] scaled(input int base, input logic [1:0] sel);
    scaled = 32'(base) * (32'(sel) + 32'h1);
  endfunction : scaled

  // Randomized sleep keeps two idle ends from waking in lock-step
  wire [31:0] jitter = 32'(lfsr) % 32'(jitter_cycles + 1);
  wire [31:0] sleep_limit = scaled(sleep_cycles, sleep_sel) + jitter; // RULE20
  wire [31:0] wake_limit = scaled(wake_cycles, wake_sel); // RULE21
  wire [31:0] link_limit = scaled(link_cycles, link_sel); // RULE22
  wire [31:0] burst_len = wake_limit / 32'(burst_count);
  wire sleep_done = count >= sleep_limit;
  wire wake_done = count >= wake_limit;
  wire link_done = count >= link_limit;
  wire detect_done = detect_count >= 32'(detect_cycles); // RULE24

  // ************************************************************
  // Energy synchronizer
  // ************************************************************
  energy_sync u_energy_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(energy_detect),
    .sync_out(energy)
  ); // RULE23

  // ************************************************************
  // Power-down state machine
  // ************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      low_power: begin
        if (energy) begin
          next_state = normal_op; // RULE4 RULE10
        end else if (sleep_done) begin
          next_state = partner_wake; // RULE3
        end
      end
      partner_wake: begin
        if (energy) begin
          next_state = normal_op; // RULE4
        end else if (wake_done) begin
          next_state = low_power; // RULE3
        end
      end
      normal_op: begin
        // Forced or autoneg-off links hold normal after a drop
        if (an_en && !forced && !sticky_normal && !link_up && link_done) begin
          next_state = low_power; // RULE5 RULE8 RULE7
        end
      end
      default: next_state = low_power;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state <= low_power; // RULE6
      count <= 32'h0;
      burst_idx <= 2'h0;
      sticky_normal <= 1'b0;
    end else if (!apd_en) begin
      state <= normal_op; // RULE1
      count <= 32'h0;
      burst_idx <= 2'h0;
      sticky_normal <= 1'b0;
    end else begin
      state <= next_state; // RULE2
      if (next_state != state || (state == normal_op && link_up)) begin
        count <= 32'h0;
      end else begin
        count <= count + 32'h1;
      end
      if (state == partner_wake && count >= burst_len * (32'(burst_idx) + 32'h1)
          && burst_idx < 2'(burst_count - 1)) begin
        burst_idx <= burst_idx + 2'h1;
      end else if (state != partner_wake) begin
        burst_idx <= 2'h0;
      end
      // Entering normal under forced speed, or autoneg turned off there
      if (state == normal_op && (!an_en || forced)) begin
        sticky_normal <= 1'b1; // RULE7 RULE8
      end else if (state != normal_op) begin
        sticky_normal <= 1'b0;
      end
    end
  end

  // LFSR runs freely for sleep randomization
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      lfsr <= 16'hACE1;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // ************************************************************
  // Inline-powered device detection
  // ************************************************************
  wire det_start = det_en && an_en; // RULE12
  wire status_read = rd && hit_detect;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      detect_active <= 1'b0;
      detect_status <= detect_searching;
      detect_irq <= 1'b0;
      link_seen <= 1'b0;
      detect_count <= 32'h0;
    end else begin
      // Own search timer: the power-down counter sits at zero while that machine is off
      detect_count <= detect_active ? detect_count + 32'h1 : 32'h0;
      if (!det_start) begin
        detect_active <= 1'b0;
        detect_status <= detect_searching;
      end else if (!detect_active && !link_seen && detect_status == detect_searching) begin
        detect_active <= 1'b1;
        detect_status <= detect_searching; // RULE13
      end else if (detect_active && pulse_loopback) begin
        detect_active <= 1'b0;
        detect_status <= detect_found; // RULE14
      end else if (detect_active && detect_done) begin
        detect_active <= 1'b0;
        detect_status <= detect_none; // RULE16 RULE17
      end
      if (detect_status == detect_none && link_up) begin
        link_seen <= 1'b1; // RULE17
      end else if (link_seen && !link_up) begin
        link_seen <= 1'b0;
        detect_status <= detect_searching; // RULE18
      end
      // Set wins over the read-clear
      if (detect_active && pulse_loopback) begin
        detect_irq <= 1'b1; // RULE15
      end else if (status_read) begin
        detect_irq <= 1'b0; // RULE15
      end
    end
  end

  // ************************************************************
  // Media-side outputs
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pulse_tx <= 1'b0;
      pulse_pair_b <= 1'b0;
      detect_pulse_tx <= 1'b0;
      autoneg_run <= 1'b0;
      digital_power_en <= 1'b0;
      management_interrupt_n_o <= 1'b0;
      management_interrupt_n_oe <= 1'b1;
    end else begin
      pulse_tx <= apd_en && state == partner_wake; // RULE11
      pulse_pair_b <= burst_idx[0]; // RULE21
      detect_pulse_tx <= detect_active; // RULE13
      autoneg_run <= an_en && !detect_active && (!det_en || detect_status == detect_none)
                     && (!apd_en || state == normal_op); // RULE17
      digital_power_en <= !apd_en || state == normal_op; // RULE9
      management_interrupt_n_o <= 1'b0;
      management_interrupt_n_oe <= !(irq_en && detect_irq); // RULE9
    end
  end

  // ************************************************************
  // APB slave, zero wait states
  // ************************************************************
  wire [31:0] read_mux = hit_ctrl ? {27'h0, ctrl} :
                         hit_timer ? {26'h0, timer_cfg} :
                         hit_status ? {28'h0, link_up, sticky_normal, state} :
                         {28'h0, detect_irq, detect_active, detect_status};

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl <= ctrl_reset;
      timer_cfg <= timer_reset;
    end else if (wr && hit_ctrl) begin
      ctrl <= pwdata[4:0]; // RULE1
    end else if (wr && hit_timer) begin
      timer_cfg <= pwdata[5:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite && mapped) ? read_mux : 32'h0;
    end
  end

endmodule : phy_link_power_manager

// >>> tb/power_chk.sv
`timescale 1ns/1ns
module power_chk #(
  parameter int wake_cycles = 20,
  parameter int detect_cycles = 15
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Media and pins
  input wire logic energy_detect,
  input wire logic pulse_loopback,
  input wire logic pulse_tx,
  input wire logic pulse_pair_b,
  input wire logic detect_pulse_tx,
  input wire logic autoneg_run,
  input wire logic digital_power_en,
  input wire logic management_interrupt_n_o
);
  // ************************************************************
  // Run-length counters
  // ************************************************************
  int wake_run;
  int search_run;
  // Loop-back ends a search legitimately, so it restarts the count
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wake_run <= 0;
      search_run <= 0;
    end else begin
      wake_run <= pulse_tx ? wake_run + 1 : 0;
      search_run <= (detect_pulse_tx && !pulse_loopback) ? search_run + 1 : 0;
    end
  end
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_energy;
    energy_detect [*8];
  endsequence
  a_ready_answer: assert property (s_setup |=> pready)
    else $error("setup cycle not answered");
  a_ready_pulse: assert property ($rose(pready) |=> $fell(pready))
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_energy_wakes: assert property (s_energy |-> digital_power_en)
    else $error("energy did not power up");
  a_wake_dark: assert property (pulse_tx |-> !digital_power_en)
    else $error("pulses sent while powered");
  a_wake_bound: assert property (pulse_tx |-> wake_run < 4 * wake_cycles + 2)
    else $error("wake period too long");
  a_search_bound: assert property (detect_pulse_tx |-> search_run <= detect_cycles + 4)
    else $error("search did not time out");
  a_search_excl: assert property (detect_pulse_tx |-> !autoneg_run)
    else $error("search and negotiation together");
  a_od_low: assert property (!management_interrupt_n_o)
    else $error("interrupt pin drives high");
  a_pair_in_wake: assert property (pulse_pair_b |-> pulse_tx)
    else $error("pair B driven outside wake");
  a_pair_a_first: assert property ($rose(pulse_tx) |-> !pulse_pair_b)
    else $error("wake burst not started on pair A");
endmodule : power_chk

// >>> tb/link_partner.sv
`timescale 1ns/1ns
module link_partner (
  // Clock
  input wire logic core_clk,
  // Scenario: 0 absent, 1 talking, 2 unpowered loop, 3 asleep until woken
  input wire logic [1:0] mode,
  input wire logic [3:0] lag,
  // Device pins
  input wire logic pulse_tx,
  input wire logic detect_pulse_tx,
  input wire logic digital_power_en,
  output logic energy_detect,
  output logic link_up,
  output logic pulse_loopback
);
  logic [4:0] wait_cnt;
  logic woken;
  initial begin
    energy_detect = 1'b0;
    link_up = 1'b0;
    pulse_loopback = 1'b0;
    woken = 1'b0;
    wait_cnt = 5'h00;
  end
  // A sleeping partner answers wake pulses only after a variable lag
  always @(posedge core_clk) begin
    woken <= (mode == 2'h3) && (woken || pulse_tx);
    if (!woken)
      wait_cnt <= 5'h00;
    else if (!energy_detect)
      wait_cnt <= wait_cnt + 5'h01;
    energy_detect <= (mode == 2'h1) || (woken && wait_cnt > {1'b0, lag});
    link_up <= energy_detect && digital_power_en;
    pulse_loopback <= (mode == 2'h2) && detect_pulse_tx;
  end
endmodule : link_partner

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench
  import power_manager_pkg::*;
;
  localparam int sc = 40;
  localparam int wc = 20;
  localparam int lc = 30;
  localparam int dc = 15;
  localparam int jc = 7;
  logic core_clk = 1'b0;
  logic nrst, psel, penable, pwrite, rerr, pready, pslverr, energy_detect, link_up;
  logic pulse_loopback, pulse_tx, pair_b, detect_pulse_tx, autoneg_run, dpe, irq_o, irq_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, seed;
  logic [1:0] mode;
  logic [3:0] lag;
  logic [5:0] tv [2] = '{6'h01, 6'h0C};
  int checks, miscompares, cyc, n, i, w, s, p, pb;
  int mdl [4];
  phy_link_power_manager #(.sleep_cycles(sc), .wake_cycles(wc), .link_cycles(lc),
    .detect_cycles(dc), .jitter_cycles(jc)) dut (.core_clk(core_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .energy_detect(energy_detect),
    .link_up(link_up), .pulse_loopback(pulse_loopback), .pulse_tx(pulse_tx),
    .pulse_pair_b(pair_b), .detect_pulse_tx(detect_pulse_tx), .autoneg_run(autoneg_run),
    .digital_power_en(dpe), .management_interrupt_n_o(irq_o),
    .management_interrupt_n_oe(irq_oe));
  link_partner partner (.core_clk(core_clk), .mode(mode), .lag(lag), .pulse_tx(pulse_tx),
    .detect_pulse_tx(detect_pulse_tx), .digital_power_en(dpe),
    .energy_detect(energy_detect), .link_up(link_up), .pulse_loopback(pulse_loopback));
  // ************************************************************
  // Bus and checking tasks
  // ************************************************************
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  // Request held until ready is sampled, then released a full cycle
  task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    chk("wait_states", k, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    mdl[a[3:2]] = d;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat & m, e);
  endtask : rd
  function logic sig(input int k);
    case (k)
      0: return pulse_tx;
      1: return dpe;
      2: return detect_pulse_tx;
      default: return autoneg_run;
    endcase
  endfunction : sig
  task wt(input int k, input logic v);
    n = 0;
    while (sig(k) !== v && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wt
  task rng(input string nm, input int lo, input int hi);
    chk(nm, {31'h0, n >= lo && n <= hi}, 32'h1);
  endtask : rng
  // Pair B cycles, a running total; the test takes its change over one wake period
  always @(posedge core_clk) begin
    if (pair_b === 1'b1)
      pb <= pb + 1;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      test_done;
    end
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, mode, lag} = '0;
    seed = 32'h00012024;
    mdl = '{int'(ctrl_reset), int'(timer_reset), 0, 0};
    repeat (5) @(posedge core_clk);
    chk("dpe_rst", {31'h0, dpe}, 32'h0);
    nrst <= 1'b1;
    rd(ctrl_offset, 32'h1F, mdl[0], "ctrl_rst");
    rd(timer_offset, 32'h3F, mdl[1], "timer_rst");
    rd(8'h10, 32'hFFFFFFFF, 32'h0, "unmapped");
    chk("slverr", {31'h0, rerr}, 32'h1);
    seed = lfsr(seed);
    wr(timer_offset, seed & 32'h3F);
    rd(timer_offset, 32'h3F, mdl[1], "timer_rw");
    $display("test registers done");
    wr(ctrl_offset, 32'h03);
    wr(timer_offset, 32'h01);
    wt(1, 1'b0);
    rng("to_low", 0, lc + 4);
    rd(status_offset, 32'h3, 32'h0, "state_low");
    for (i = 0; i < 2; i++) begin
      wr(timer_offset, {26'h0, tv[i]});
      w = wc * (tv[i][3:2] + 1);
      s = sc * (tv[i][1:0] + 1);
      wt(0, 1'b1);
      rd(status_offset, 32'h3, 32'h1, "state_wake");
      wt(0, 1'b0);
      wt(0, 1'b1);
      p = pb;
      wt(0, 1'b0);
      rng("wake_len", w - 1, w + 1);
      n = pb - p;
      rng("pair_b", w / 3 - 1, w / 3 + 1);
      wt(0, 1'b1);
      rng("sleep_len", s - 1, s + jc + 1);
    end
    $display("test cycling done");
    wr(timer_offset, 32'h31);
    seed = lfsr(seed);
    lag <= seed[3:0];
    mode <= 2'h3;
    wt(1, 1'b1);
    rng("woken", 0, 2 * sc + wc + 60);
    repeat (4) @(posedge core_clk);
    rd(status_offset, 32'hB, 32'hB, "normal_link");
    mode <= 2'h0;
    wt(1, 1'b0);
    rng("link_timeout", 4 * lc - 2, 4 * lc + 8);
    $display("test wake done");
    for (i = 0; i < 2; i++) begin
      // Power-down off and on again clears the hold left by the forced pass
      if (i)
        wr(ctrl_offset, 32'h02);
      wr(ctrl_offset, i ? 32'h03 : 32'h09);
      mode <= 2'h1;
      wt(1, 1'b1);
      if (i)
        wr(ctrl_offset, 32'h01);
      mode <= 2'h0;
      repeat (6 * lc) @(posedge core_clk);
      rd(status_offset, 32'h7, 32'h7, "stay_normal");
    end
    $display("test forced done");
    wr(ctrl_offset, 32'h16);
    rd(detect_offset, 32'h3, {30'h0, detect_searching}, "searching");
    chk("search_tx", {31'h0, detect_pulse_tx}, 32'h1);
    wt(3, 1'b1);
    rng("no_loop", dc - 8, dc + 4);
    rd(detect_offset, 32'h3, {30'h0, detect_none}, "none");
    mode <= 2'h1;
    repeat (12) @(posedge core_clk);
    rd(status_offset, 32'h8, 32'h8, "link_set");
    mode <= 2'h0;
    wt(2, 1'b1);
    rng("resume", 0, 12);
    mode <= 2'h2;
    repeat (8) @(posedge core_clk);
    chk("irq_pin", {31'h0, irq_oe}, 32'h0);
    rd(detect_offset, 32'hB, {28'h0, 2'b10, detect_found}, "found");
    rd(detect_offset, 32'h8, 32'h0, "irq_clr");
    chk("irq_off", {31'h0, irq_oe}, 32'h1);
    wr(ctrl_offset, 32'h02);
    mode <= 2'h0;
    $display("test detection done");
    test_done;
  end
endmodule : testbench
bind phy_link_power_manager power_chk #(.wake_cycles(wake_cycles),
  .detect_cycles(detect_cycles)) u_chk (.core_clk(core_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .energy_detect(energy_detect),
  .pulse_loopback(pulse_loopback), .pulse_tx(pulse_tx), .pulse_pair_b(pulse_pair_b),
  .detect_pulse_tx(detect_pulse_tx),
  .autoneg_run(autoneg_run), .digital_power_en(digital_power_en),
  .management_interrupt_n_o(management_interrupt_n_o));
